// [rtl/kdc_pkg.sv]
// Types shared by the keyboard/display controller.
`default_nettype none
package kdc_pkg;
	typedef enum logic [2:0] {
		kdc_key_idle = 3'h1,
		kdc_key_wait = 3'h2,
		kdc_key_held = 3'h4
	} kdc_key_state_t;

	typedef struct packed {
		logic du;
		logic se;
		logic ovr;
		logic und;
		logic full;
		logic [2:0] cnt;
	} kdc_status_t;

	typedef struct packed {
		logic [1:0] dd;
		logic [2:0] keyboard_mode_field;
		logic [4:0] presc;
		logic err_mode;
		logic rd_fifo_sel;
		logic ai;
		logic [3:0] disp_addr;
		logic [2:0] row_ptr;
		logic inhibit_write_nibble_a;
		logic inhibit_write_nibble_b;
		logic blank_nibble_a;
		logic blank_nibble_b;
		logic se;
		logic ovr;
		logic und;
		logic sens_irq;
		logic sens_lock;
		logic disp_busy;
		logic [3:0] busy_rows;
		logic [4:0] pre_cnt;
		logic [5:0] tick_cnt;
		logic [3:0] scan_cnt;
		kdc_key_state_t key_st;
		logic [2:0] key_row;
		logic [2:0] key_col;
		logic [4:0] key_wait;
		logic rd_n_q;
		logic wr_n_q;
		logic stb_q;
		logic [15:0][7:0] disp_ram;
		logic [7:0][7:0] sens_ram;
		logic [7:0] rdata;
		logic data_oe;
		logic irq;
		logic [3:0] scan_out;
		logic [3:0] out_a;
		logic [3:0] out_b;
		logic blank;
	} kdc_core_t;
endpackage : kdc_pkg
`default_nettype wire

// [rtl/kdc_regs.svh]
// Command codes, field positions, reset values and timing counts of the keyboard/display controller.
`ifndef KDC_REGS_SVH
`define KDC_REGS_SVH
`define KDC_OP_MODE 3'h0
`define KDC_OP_CLOCK 3'h1
`define KDC_OP_RD_FIFO 3'h2
`define KDC_OP_RD_DISP 3'h3
`define KDC_OP_WR_DISP 3'h4
`define KDC_OP_INH_BLANK 3'h5
`define KDC_OP_CLEAR 3'h6
`define KDC_OP_END_INT 3'h7
`define KDC_OP_MSB 7
`define KDC_OP_LSB 5
`define KDC_DD_MSB 4
`define KDC_DD_LSB 3
`define KDC_KKK_MSB 2
`define KDC_KKK_LSB 0
`define KDC_PRESC_MSB 4
`define KDC_AI_BIT 4
`define KDC_ERR_BIT 4
`define KDC_ROW_MSB 2
`define KDC_ADDR_MSB 3
`define KDC_IWA_BIT 3
`define KDC_IWB_BIT 2
`define KDC_BLA_BIT 1
`define KDC_BLB_BIT 0
`define KDC_CD_MSB 4
`define KDC_CD_LSB 2
`define KDC_CF_BIT 1
`define KDC_CA_BIT 0
`define KDC_DD_RST 2'h1
`define KDC_KKK_RST 3'h0
`define KDC_PRESC_RST 5'h1f
`define KDC_PRESC_MIN 5'h02
`define KDC_FILL_ZERO 8'h00
`define KDC_FILL_SPACE 8'h20
`define KDC_FILL_ONES 8'hff
`define KDC_SCAN_MAX_DEC 4'h3
`define KDC_SCAN_MAX_8 4'h7
`define KDC_SCAN_MAX_16 4'hf
`define KDC_ADDR_MASK_8 4'h7
`define KDC_ADDR_MASK_16 4'hf
`define KDC_INT_CYCLE_NS 10000
`define KDC_ROW_TIME_NS 640000
`define KDC_BLANK_TIME_NS 160000
`define KDC_ROW_TICKS (`KDC_ROW_TIME_NS / `KDC_INT_CYCLE_NS)
`define KDC_BLANK_TICKS (`KDC_BLANK_TIME_NS / `KDC_INT_CYCLE_NS)
`define KDC_DEBOUNCE_ROWS 16
`endif

// [rtl/kdc_top.sv]
// Keyboard/display controller: bus port, timing chain, scanner, key FIFO and display refresh.
//
// Function
// - Buffer select: low data, high command/status.
// - Data bus drivers off while chip deselected.
// - Prescaler 2..31 divides clock, resets to 31.
// - 100 kHz gives 5.1 ms scan, 10.3 ms debounce.
// - Encoded count active high, decoded one-of-four low.
// - Closure rechecked after debounce, then queued with shift/control.
// - Sensor mode copies return lines to sensor row.
// - Strobed mode queues return lines on strobe rise.
// - Eight-entry FIFO; interrupt while any entry held.
// - Sensor change holds interrupt until acknowledged.
// - Display address auto-increments; left or right entry.
// - Mode set selects 8/16 characters, entry side.
// - Keyboard field selects scan, sensor or strobe mode.
// - FIFO read command loads row, optional auto-increment.
// - Display read/write commands load address and increment.
// - Per-nibble write inhibit and blank flags, reset zero.
// - Clear command fills display, clears FIFO or all.
// - Display clear lasts one scan, refuses writes, unavailable.
// - FIFO clear empties, drops interrupt, row pointer zero.
// - Clear-all clears both and resynchronises timing chain.
// - End interrupt acknowledges sensor, sets error mode.
// - Status byte: unavailable, error, overrun, underrun, full, count.
// - Interrupt drops on each data read, returns if entries.
// - Key entry: control, shift, row, column.
// - High reset returns device to defaults.
`timescale 1ns/1ps
`include "kdc_regs.svh"
`default_nettype none

// ****************************************
// Entry queue
// ****************************************
module kdc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} kdc_fifo_st_t;
	kdc_fifo_st_t st_ff;
	kdc_fifo_st_t nxt_st;
	logic do_push;
	logic do_pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
		$error("kdc_fifo needs a power-of-two depth of at least two");
	end

	assign o_in_ready = st_ff.count != (AW + 1)'(DEPTH);
	assign o_out_valid = st_ff.count != '0;
	assign o_out_data = st_ff.mem[st_ff.rd_ptr];
	assign o_count = st_ff.count;
	assign do_push = i_in_valid && o_in_ready;
	assign do_pop = i_out_ready && o_out_valid;

	always_comb begin
		nxt_st = st_ff;
		if (do_push) begin
			nxt_st.mem[st_ff.wr_ptr] = i_in_data;
			nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
		end
		if (do_pop) begin
			nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
		end
		if (do_push && !do_pop) begin
			nxt_st.count = st_ff.count + (AW + 1)'(1);
		end else if (do_pop && !do_push) begin
			nxt_st.count = st_ff.count - (AW + 1)'(1);
		end
		// A flush outranks a push in the same cycle; the entry is dropped.
		if (i_flush) begin
			nxt_st.wr_ptr = '0;
			nxt_st.rd_ptr = '0;
			nxt_st.count = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : kdc_fifo

// ****************************************
// Controller
// ****************************************
module kdc_top #(
	parameter int unsigned FIFO_WIDTH = 8,
	parameter int unsigned FIFO_DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_buffer_select,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_irq,
	output logic [3:0] o_scan_outputs,
	output logic [3:0] o_disp_a,
	output logic [3:0] o_disp_b,
	output logic o_blank_display,
	input wire logic [7:0] i_return_lines,
	input wire logic i_shift_state,
	input wire logic i_control_strobe_input
);
	localparam logic [5:0] ROW_LAST = 6'(`KDC_ROW_TICKS - 1);
	localparam logic [5:0] BLANK_TICKS = 6'(`KDC_BLANK_TICKS);
	localparam logic [4:0] DEB_LAST = 5'(`KDC_DEBOUNCE_ROWS - 1);
	localparam int unsigned CW = $clog2(FIFO_DEPTH) + 1;

	if (FIFO_WIDTH != 8 || FIFO_DEPTH != 8) begin : g_bad_top
		$error("kdc_top serves only an 8 by 8 entry queue");
	end

	kdc_pkg::kdc_core_t st_ff;
	kdc_pkg::kdc_core_t nxt_st;
	kdc_pkg::kdc_status_t status_w;
	logic rd_edge;
	logic wr_edge;
	logic data_rd;
	logic stat_rd;
	logic data_wr;
	logic cmd_wr;
	logic [2:0] op;
	logic key_mode;
	logic sensor_mode;
	logic strobe_mode;
	logic tick;
	logic row_step;
	logic [3:0] scan_max;
	logic [2:0] row;
	logic [7:0] rl_low;
	logic stb_rise;
	logic sens_hit;
	logic clr_fifo;
	logic clr_disp;
	logic fifo_rd;
	logic push_valid;
	logic [7:0] push_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic [CW-1:0] fifo_count;

	function automatic logic is_decoded(input logic [2:0] keyboard_mode_field);
		return keyboard_mode_field[0];
	endfunction : is_decoded

	function automatic logic [3:0] next_addr(input logic [3:0] a, input logic wide);
		return (a + 4'h1) & (wide ? `KDC_ADDR_MASK_16 : `KDC_ADDR_MASK_8);
	endfunction : next_addr

	function automatic logic [2:0] first_low(input logic [7:0] low);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (low[i]) begin
				c = 3'(i);
			end
		end
		return c;
	endfunction : first_low

	function automatic logic [7:0] fill_code(input logic [2:0] cd);
		logic [7:0] f;
		f = `KDC_FILL_ZERO;
		if (cd[2] && cd[1]) begin
			f = cd[0] ? `KDC_FILL_ONES : `KDC_FILL_SPACE;
		end
		return f;
	endfunction : fill_code

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
		input logic inhibit_write_nibble_a, input logic inhibit_write_nibble_b);
		return {inhibit_write_nibble_a ? old[7:4] : d[7:4], inhibit_write_nibble_b ? old[3:0] : d[3:0]};
	endfunction : merge

	// Strobes are sampled on the core clock; an access acts once, on its leading edge.
	assign rd_edge = !i_cs_n && !i_rd_n && st_ff.rd_n_q;
	assign wr_edge = !i_cs_n && !i_wr_n && st_ff.wr_n_q;
	assign data_rd = rd_edge && !i_buffer_select;
	assign stat_rd = rd_edge && i_buffer_select;
	assign data_wr = wr_edge && !i_buffer_select;
	assign cmd_wr = wr_edge && i_buffer_select;
	assign op = i_data[`KDC_OP_MSB:`KDC_OP_LSB];
	assign key_mode = !st_ff.keyboard_mode_field[2];
	assign sensor_mode = st_ff.keyboard_mode_field[2] && !st_ff.keyboard_mode_field[1];
	assign strobe_mode = st_ff.keyboard_mode_field[2] && st_ff.keyboard_mode_field[1];
	assign tick = st_ff.pre_cnt >= st_ff.presc - 5'h01;
	assign row_step = tick && st_ff.tick_cnt == ROW_LAST;
	assign scan_max = is_decoded(st_ff.keyboard_mode_field) ? `KDC_SCAN_MAX_DEC
		: (st_ff.dd[0] ? `KDC_SCAN_MAX_16 : `KDC_SCAN_MAX_8);
	assign row = st_ff.scan_cnt[2:0];
	assign rl_low = ~i_return_lines;
	assign stb_rise = i_control_strobe_input && !st_ff.stb_q;
	assign sens_hit = row_step && sensor_mode && !st_ff.sens_lock
		&& i_return_lines != st_ff.sens_ram[row];
	assign clr_fifo = cmd_wr && op == `KDC_OP_CLEAR
		&& (i_data[`KDC_CF_BIT] || i_data[`KDC_CA_BIT]);
	assign clr_disp = cmd_wr && op == `KDC_OP_CLEAR
		&& (i_data[`KDC_CD_MSB] || i_data[`KDC_CA_BIT]);
	assign fifo_rd = data_rd && st_ff.rd_fifo_sel && !sensor_mode;
	assign status_w = '{du: st_ff.disp_busy, se: st_ff.se, ovr: st_ff.ovr, und: st_ff.und,
		full: !fifo_in_ready, cnt: fifo_count[2:0]};

	kdc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_core_clk),
		.i_rst(i_rst),
		.i_flush(clr_fifo),
		.i_in_valid(push_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_rd),
		.o_out_data(fifo_out_data),
		.o_count(fifo_count)
	);

	always_comb begin
		nxt_st = st_ff;
		push_valid = 1'b0;
		push_data = '0;
		nxt_st.rd_n_q = i_rd_n;
		nxt_st.wr_n_q = i_wr_n;
		nxt_st.stb_q = i_control_strobe_input;

		// ****************************************
		// Timing chain
		// ****************************************
		nxt_st.pre_cnt = tick ? 5'h00 : st_ff.pre_cnt + 5'h01;
		nxt_st.tick_cnt = !tick ? st_ff.tick_cnt : (row_step ? 6'h00 : st_ff.tick_cnt + 6'h01);
		if (row_step) begin
			nxt_st.scan_cnt = (st_ff.scan_cnt >= scan_max) ? 4'h0 : st_ff.scan_cnt + 4'h1;
		end
		if (st_ff.disp_busy && row_step) begin
			nxt_st.busy_rows = st_ff.busy_rows + 4'h1;
			if (st_ff.busy_rows == scan_max) begin
				nxt_st.disp_busy = 1'b0;
			end
		end

		// ****************************************
		// Return line scanning
		// ****************************************
		// After a change every sensor row is frozen until acknowledged, so the reported change survives.
		if (sens_hit) begin
			nxt_st.sens_ram[row] = i_return_lines;
			nxt_st.sens_irq = 1'b1;
			nxt_st.sens_lock = 1'b1;
		end
		if (row_step && key_mode) begin
			case (st_ff.key_st)
			kdc_pkg::kdc_key_idle: begin
				if (rl_low != 8'h00) begin
					nxt_st.key_st = kdc_pkg::kdc_key_wait;
					nxt_st.key_row = row;
					nxt_st.key_col = first_low(rl_low);
					nxt_st.key_wait = 5'h00;
				end
			end
			kdc_pkg::kdc_key_wait: begin
				nxt_st.key_wait = st_ff.key_wait + 5'h01;
				// The scan period divides the debounce span, so this is the key's own row again.
				if (st_ff.key_wait == DEB_LAST) begin
					nxt_st.key_st = kdc_pkg::kdc_key_idle;
					if (rl_low[st_ff.key_col]) begin
						nxt_st.key_st = kdc_pkg::kdc_key_held;
						push_valid = 1'b1;
						push_data = {i_control_strobe_input, i_shift_state, st_ff.key_row,
							st_ff.key_col};
					end
					if (st_ff.err_mode && st_ff.keyboard_mode_field[1] && !$onehot0(rl_low)) begin
						nxt_st.se = 1'b1;
					end
				end
			end
			kdc_pkg::kdc_key_held: begin
				if (row == st_ff.key_row && !rl_low[st_ff.key_col]) begin
					nxt_st.key_st = kdc_pkg::kdc_key_idle;
				end
			end
			default: begin
				nxt_st.key_st = kdc_pkg::kdc_key_idle;
			end
			endcase
		end
		if (strobe_mode && stb_rise) begin
			push_valid = 1'b1;
			push_data = i_return_lines;
		end

		// ****************************************
		// Commands
		// ****************************************
		if (cmd_wr) begin
			case (op)
			`KDC_OP_MODE: begin
				nxt_st.dd = i_data[`KDC_DD_MSB:`KDC_DD_LSB];
				nxt_st.keyboard_mode_field = i_data[`KDC_KKK_MSB:`KDC_KKK_LSB];
			end
			`KDC_OP_CLOCK: begin
				nxt_st.presc = (i_data[`KDC_PRESC_MSB:0] < `KDC_PRESC_MIN) ? `KDC_PRESC_MIN
					: i_data[`KDC_PRESC_MSB:0];
			end
			`KDC_OP_RD_FIFO: begin
				nxt_st.rd_fifo_sel = 1'b1;
				nxt_st.ai = i_data[`KDC_AI_BIT];
				nxt_st.row_ptr = i_data[`KDC_ROW_MSB:0];
			end
			`KDC_OP_RD_DISP, `KDC_OP_WR_DISP: begin
				nxt_st.rd_fifo_sel = 1'b0;
				nxt_st.ai = i_data[`KDC_AI_BIT];
				nxt_st.disp_addr = i_data[`KDC_ADDR_MSB:0];
			end
			`KDC_OP_INH_BLANK: begin
				nxt_st.inhibit_write_nibble_a = i_data[`KDC_IWA_BIT];
				nxt_st.inhibit_write_nibble_b = i_data[`KDC_IWB_BIT];
				nxt_st.blank_nibble_a = i_data[`KDC_BLA_BIT];
				nxt_st.blank_nibble_b = i_data[`KDC_BLB_BIT];
			end
			`KDC_OP_CLEAR: begin
				if (clr_disp) begin
					nxt_st.disp_ram = {16{fill_code(i_data[`KDC_CD_MSB:`KDC_CD_LSB])}};
					nxt_st.disp_busy = 1'b1;
					nxt_st.busy_rows = 4'h0;
				end
				if (clr_fifo) begin
					nxt_st.ovr = 1'b0;
					nxt_st.und = 1'b0;
					// A change caught in the clearing cycle stays reported, or it would be lost.
					nxt_st.sens_irq = sens_hit;
					nxt_st.sens_lock = sens_hit;
					nxt_st.row_ptr = 3'h0;
				end
				if (i_data[`KDC_CA_BIT]) begin
					nxt_st.pre_cnt = 5'h00;
					nxt_st.tick_cnt = 6'h00;
					nxt_st.scan_cnt = 4'h0;
				end
			end
			`KDC_OP_END_INT: begin
				nxt_st.sens_irq = sens_hit;
				nxt_st.sens_lock = sens_hit;
				nxt_st.err_mode = i_data[`KDC_ERR_BIT];
			end
			default: begin
				nxt_st.ai = st_ff.ai;
			end
			endcase
		end

		// ****************************************
		// Data transfers
		// ****************************************
		if (data_wr && !st_ff.disp_busy) begin
			if (st_ff.dd[1]) begin
				for (int i = 0; i < 15; i++) begin
					if (4'(i) < scan_max) begin
						nxt_st.disp_ram[i] = st_ff.disp_ram[i + 1];
					end
				end
				nxt_st.disp_ram[scan_max] = merge(st_ff.disp_ram[scan_max], i_data,
					st_ff.inhibit_write_nibble_a, st_ff.inhibit_write_nibble_b);
			end else begin
				nxt_st.disp_ram[st_ff.disp_addr] = merge(st_ff.disp_ram[st_ff.disp_addr], i_data,
					st_ff.inhibit_write_nibble_a, st_ff.inhibit_write_nibble_b);
				if (st_ff.ai) begin
					nxt_st.disp_addr = next_addr(st_ff.disp_addr, st_ff.dd[0]);
				end
			end
		end
		if (stat_rd) begin
			nxt_st.rdata = status_w;
		end
		if (data_rd) begin
			if (!st_ff.rd_fifo_sel) begin
				nxt_st.rdata = st_ff.disp_ram[st_ff.disp_addr];
				if (st_ff.ai) begin
					nxt_st.disp_addr = next_addr(st_ff.disp_addr, st_ff.dd[0]);
				end
			end else if (sensor_mode) begin
				nxt_st.rdata = st_ff.sens_ram[st_ff.row_ptr];
				if (st_ff.ai) begin
					nxt_st.row_ptr = st_ff.row_ptr + 3'h1;
				end
			end else begin
				nxt_st.rdata = fifo_out_data;
				if (!fifo_out_valid) begin
					nxt_st.und = 1'b1;
				end
			end
		end
		if (push_valid && !fifo_in_ready) begin
			nxt_st.ovr = 1'b1;
		end
		nxt_st.data_oe = !i_cs_n && !i_rd_n;
		nxt_st.irq = (sensor_mode ? nxt_st.sens_irq : fifo_out_valid)
			&& !data_rd && !clr_fifo;

		// ****************************************
		// Scan and display outputs
		// ****************************************
		nxt_st.scan_out = is_decoded(nxt_st.keyboard_mode_field) ? ~(4'h1 << nxt_st.scan_cnt[1:0])
			: nxt_st.scan_cnt;
		nxt_st.blank = nxt_st.tick_cnt < BLANK_TICKS || (nxt_st.blank_nibble_a && nxt_st.blank_nibble_b);
		nxt_st.out_a = (nxt_st.tick_cnt < BLANK_TICKS || nxt_st.blank_nibble_a) ? 4'h0
			: nxt_st.disp_ram[nxt_st.scan_cnt][7:4];
		nxt_st.out_b = (nxt_st.tick_cnt < BLANK_TICKS || nxt_st.blank_nibble_b) ? 4'h0
			: nxt_st.disp_ram[nxt_st.scan_cnt][3:0];
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.dd <= `KDC_DD_RST;
			st_ff.keyboard_mode_field <= `KDC_KKK_RST;
			st_ff.presc <= `KDC_PRESC_RST;
			st_ff.key_st <= kdc_pkg::kdc_key_idle;
			st_ff.rd_n_q <= 1'b1;
			st_ff.wr_n_q <= 1'b1;
			st_ff.stb_q <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_data = st_ff.rdata;
	assign o_data_oe = st_ff.data_oe;
	assign o_irq = st_ff.irq;
	assign o_scan_outputs = st_ff.scan_out;
	assign o_disp_a = st_ff.out_a;
	assign o_disp_b = st_ff.out_b;
	assign o_blank_display = st_ff.blank;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb_core @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	property p_bus_release;
		i_cs_n |=> !o_data_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("data bus driven while deselected");

	property p_presc_default;
		$past(i_rst) |-> st_ff.presc == `KDC_PRESC_RST;
	endproperty
	a_presc_default: assert property (p_presc_default) else $error("prescaler not 31 after reset");

	property p_decoded_scan;
		is_decoded(st_ff.keyboard_mode_field) |-> $onehot(~o_scan_outputs);
	endproperty
	a_decoded_scan: assert property (p_decoded_scan) else $error("decoded scan not one-of-four low");

	property p_irq_fifo;
		(!sensor_mode && fifo_count != '0 && !data_rd && !clr_fifo) |=> o_irq;
	endproperty
	a_irq_fifo: assert property (p_irq_fifo) else $error("interrupt low with entries held");

	property p_irq_drop;
		(!sensor_mode && data_rd) |=> !o_irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("interrupt did not drop on read");

	property p_du_set;
		clr_disp |=> st_ff.disp_busy && status_w.du;
	endproperty
	a_du_set: assert property (p_du_set) else $error("display clear not reported unavailable");

	property p_wr_refused;
		(st_ff.disp_busy && data_wr) |=> st_ff.disp_ram == $past(st_ff.disp_ram);
	endproperty
	a_wr_refused: assert property (p_wr_refused) else $error("display written during clear");

	property p_fifo_clear;
		clr_fifo |=> fifo_count == '0 && !o_irq && st_ff.row_ptr == '0
			##1 (fifo_count == '0 || $past(push_valid));
	endproperty
	a_fifo_clear: assert property (p_fifo_clear) else $error("FIFO clear incomplete");

	property p_strobe_push;
		(strobe_mode && stb_rise && fifo_in_ready && !clr_fifo && !fifo_rd)
			|=> fifo_count == $past(fifo_count) + CW'(1);
	endproperty
	a_strobe_push: assert property (p_strobe_push) else $error("strobe did not queue an entry");

	c_key_push: cover property (key_mode && push_valid);
	c_clear_scan: cover property (clr_disp ##1 st_ff.disp_busy [*8]);
	c_sensor_irq: cover property (sensor_mode && $rose(st_ff.sens_irq));
endmodule : kdc_top
`default_nettype wire

// [sim/kdc_keypad.sv]
// Key matrix model: one key that joins a scan row to one return line.
`timescale 1ns/1ps
`default_nettype none
module kdc_keypad (
	input wire logic [3:0] i_scan,
	input wire logic i_press,
	input wire logic [2:0] i_row,
	input wire logic [2:0] i_col,
	output logic [7:0] o_return_lines
);
	// Return lines have pull-ups, so an open key or an unscanned row reads high.
	always_comb begin
		o_return_lines = 8'hff;
		if (i_press && i_scan[2:0] == i_row) begin
			o_return_lines[i_col] = 1'b0;
		end
	end
endmodule : kdc_keypad
`default_nettype wire

// [sim/tb_kdc_top.sv]
// Self-checking testbench of the keyboard/display controller.
`timescale 1ns/1ps
`default_nettype none
module tb_kdc_top;
	logic core_clk, rst, cs_n, bsel, rd_n, wr_n, stb, shift, press, data_oe, irq, blank, f;
	logic [3:0] scan, disp_a, disp_b;
	logic [7:0] wdat, rdat, rl_drv, kp_lines, v;
	int n_fail, total_checks;
	kdc_top DUT (
		.i_core_clk(core_clk),
		.i_rst(rst),
		.i_cs_n(cs_n),
		.i_buffer_select(bsel),
		.i_rd_n(rd_n),
		.i_wr_n(wr_n),
		.i_data(wdat),
		.o_data(rdat),
		.o_data_oe(data_oe),
		.o_irq(irq),
		.o_scan_outputs(scan),
		.o_disp_a(disp_a),
		.o_disp_b(disp_b),
		.o_blank_display(blank),
		.i_return_lines(rl_drv & kp_lines),
		.i_shift_state(shift),
		.i_control_strobe_input(stb)
	);
	kdc_keypad u_keypad (
		.i_scan(scan),
		.i_press(press),
		.i_row(3'h2),
		.i_col(3'h5),
		.o_return_lines(kp_lines)
	);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic bus_wr(input logic sel, input logic [7:0] d);
		cs_n <= 1'b0;
		bsel <= sel;
		wr_n <= 1'b0;
		wdat <= d;
		@(posedge core_clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge core_clk);
	endtask : bus_wr
	// Outputs are sampled at the falling edge so the registered answer has surely landed.
	task automatic bus_rd(input logic sel, output logic [7:0] d, output logic lo);
		cs_n <= 1'b0;
		bsel <= sel;
		rd_n <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		d = rdat;
		lo = irq;
		check("data_oe", 8'h01, {7'h0, data_oe});
		@(posedge core_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge core_clk);
	endtask : bus_rd
	task automatic rd_chk(input logic sel, input logic [7:0] exp, input string what);
		bus_rd(sel, v, f);
		check(what, exp, v);
	endtask : rd_chk
	task automatic wait_irq(input int bound);
		for (int i = 0; i < bound; i++) begin
			@(posedge core_clk);
			if (irq === 1'b1) return;
		end
		check("irq wait", 8'h01, 8'h00);
		tally_and_finish();
	endtask : wait_irq
	task automatic wait_idle();
		for (int i = 0; i < 1500; i++) begin
			bus_rd(1'b1, v, f);
			if (v[7] === 1'b0) return;
		end
		check("display busy", 8'h00, 8'h80);
		tally_and_finish();
	endtask : wait_idle
	task automatic push_strobe(input logic [7:0] d);
		rl_drv <= d;
		stb <= 1'b0;
		@(posedge core_clk);
		stb <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask : push_strobe
	// *****************************
	// Scenarios
	// *****************************
	task automatic t_reset();
		check("irq", 8'h00, {7'h0, irq});
		rd_chk(1'b1, 8'h00, "status");
		rd_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		check("oe deselected", 8'h00, {7'h0, data_oe});
		rd_n <= 1'b1;
		@(posedge core_clk);
		$display("test reset done");
	endtask : t_reset
	task automatic t_strobe();
		bus_wr(1'b1, 8'h0e);
		for (int i = 0; i < 9; i++) begin
			push_strobe(8'ha0 + 8'(i));
		end
		rl_drv <= 8'hff;
		check("irq", 8'h01, {7'h0, irq});
		rd_chk(1'b1, 8'h28, "status full");
		bus_wr(1'b1, 8'h40);
		rd_chk(1'b0, 8'ha0, "fifo head");
		check("irq drop", 8'h00, {7'h0, f});
		check("irq back", 8'h01, {7'h0, irq});
		for (int i = 1; i < 8; i++) begin
			rd_chk(1'b0, 8'ha0 + 8'(i), "fifo order");
		end
		rd_chk(1'b1, 8'h20, "status drained");
		bus_rd(1'b0, v, f);
		rd_chk(1'b1, 8'h30, "status underrun");
		bus_wr(1'b1, 8'hc2);
		rd_chk(1'b1, 8'h00, "status cleared");
		check("irq cleared", 8'h00, {7'h0, irq});
		$display("test strobe done");
	endtask : t_strobe
	task automatic t_display();
		bus_wr(1'b1, 8'h90);
		bus_wr(1'b0, 8'h12);
		bus_wr(1'b0, 8'h34);
		bus_wr(1'b1, 8'h70);
		rd_chk(1'b0, 8'h12, "disp 0");
		rd_chk(1'b0, 8'h34, "disp 1");
		bus_wr(1'b1, 8'ha8);
		bus_wr(1'b1, 8'h90);
		bus_wr(1'b0, 8'hff);
		bus_wr(1'b1, 8'ha0);
		bus_wr(1'b1, 8'h70);
		rd_chk(1'b0, 8'h1f, "inhibit a");
		bus_wr(1'b1, 8'h16);
		bus_wr(1'b0, 8'h11);
		bus_wr(1'b0, 8'h22);
		bus_wr(1'b1, 8'h76);
		rd_chk(1'b0, 8'h11, "right entry 6");
		rd_chk(1'b0, 8'h22, "right entry 7");
		bus_wr(1'b1, 8'h0e);
		$display("test display done");
	endtask : t_display
	task automatic t_clear();
		logic [7:0] cmd [4];
		logic [7:0] fill [4];
		cmd = '{8'hdc, 8'hd0, 8'hd8, 8'hc1};
		fill = '{8'hff, 8'h00, 8'h20, 8'h00};
		bus_wr(1'b1, 8'h22);
		for (int k = 0; k < 4; k++) begin
			bus_wr(1'b1, cmd[k]);
			rd_chk(1'b1, 8'h80, "unavailable");
			bus_wr(1'b1, 8'h90);
			bus_wr(1'b0, 8'h55);
			wait_idle();
			bus_wr(1'b1, 8'h70);
			rd_chk(1'b0, fill[k], "fill");
		end
		bus_wr(1'b1, 8'h90);
		bus_wr(1'b0, 8'h77);
		bus_wr(1'b1, 8'hc0);
		rd_chk(1'b1, 8'h00, "no clear status");
		bus_wr(1'b1, 8'h70);
		rd_chk(1'b0, 8'h77, "no clear");
		for (int i = 0; i < 3000 && !(scan == 4'h0 && blank === 1'b0); i++) begin
			@(posedge core_clk);
		end
		check("scan", 8'h00, {4'h0, scan});
		check("unblanked", 8'h00, {7'h0, blank});
		check("nibble a", 8'h07, {4'h0, disp_a});
		check("nibble b", 8'h07, {4'h0, disp_b});
		bus_wr(1'b1, 8'ha3);
		check("blanked", 8'h01, {7'h0, blank});
		check("blank a", 8'h00, {4'h0, disp_a});
		bus_wr(1'b1, 8'ha0);
		$display("test clear done");
	endtask : t_clear
	task automatic t_key();
		bus_wr(1'b1, 8'h08);
		press <= 1'b1;
		wait_irq(8000);
		bus_wr(1'b1, 8'h40);
		rd_chk(1'b0, 8'h95, "key entry");
		press <= 1'b0;
		bus_wr(1'b1, 8'h09);
		repeat (300) @(posedge core_clk);
		check("decoded", 8'h01, {7'h0, scan inside {4'he, 4'hd, 4'hb, 4'h7}});
		$display("test key done");
	endtask : t_key
	task automatic t_sensor();
		press <= 1'b1;
		bus_wr(1'b1, 8'h04);
		for (int r = 0; r < 8; r++) begin
			wait_irq(1100);
			bus_wr(1'b1, 8'he0);
		end
		repeat (1100) @(posedge core_clk);
		check("sensor settled", 8'h00, {7'h0, irq});
		bus_wr(1'b1, 8'h50);
		for (int r = 0; r < 8; r++) begin
			rd_chk(1'b0, (r == 2) ? 8'hdf : 8'hff, "sensor row");
		end
		press <= 1'b0;
		wait_irq(1100);
		repeat (300) @(posedge core_clk);
		check("sensor held", 8'h01, {7'h0, irq});
		bus_wr(1'b1, 8'h42);
		rd_chk(1'b0, 8'hff, "sensor change");
		bus_wr(1'b1, 8'he0);
		check("sensor ack", 8'h00, {7'h0, irq});
		$display("test sensor done");
	endtask : t_sensor
	initial begin
		n_fail = 0;
		total_checks = 0;
		{rst, cs_n, rd_n, wr_n, stb} = 5'h1f;
		{bsel, shift, press} = 3'h0;
		wdat = 8'h00;
		rl_drv = 8'hff;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_strobe();
		t_display();
		t_clear();
		t_key();
		t_sensor();
		tally_and_finish();
	end
endmodule : tb_kdc_top
`default_nettype wire
